// ### hdl/ddeb_defines.vh
// register offsets, field positions, reset values and timing of the diagnostic bank
`ifndef DDEB_DEFINES_VH
`define DDEB_DEFINES_VH

`define DDEB_ADDR_W 6
`define DDEB_DATA_W 8
`define DDEB_NCH 8

`define DDEB_OFS_DIG_EN 6'h21
`define DDEB_OFS_DIG_ERR 6'h22
`define DDEB_OFS_OPEN_EN 6'h23
`define DDEB_OFS_OPEN_FLG 6'h24
`define DDEB_OFS_RNG_EN 6'h25
`define DDEB_OFS_OVR_FLG 6'h26
`define DDEB_OFS_UND_FLG 6'h27

`define DDEB_RST_DIG_EN 8'h01
`define DDEB_RST_ZERO 8'h00
`define DDEB_RST_SAMPLE 16'h0000

`define DDEB_BIT_IFCHK 7
`define DDEB_BIT_CLKMON 6
`define DDEB_BIT_STUCK 5
`define DDEB_BIT_RDERR 4
`define DDEB_BIT_WRERR 3
`define DDEB_BIT_IFCRC 2
`define DDEB_BIT_MMCRC 1
`define DDEB_BIT_ROMCRC 0
`define DDEB_ERR_MASK 8'h3F

`define DDEB_FIXED_WORD 16'hACE1

`define DDEB_CLK_MHZ 40
`define DDEB_STUCK_US 4
`define DDEB_STUCK_CYC (`DDEB_STUCK_US * `DDEB_CLK_MHZ)
`define DDEB_CNT_W 8
`define DDEB_MON_W 16

`endif

// ### hdl/ddeb_sync.v
// per-bit two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ddeb_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // data
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_i[g];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[g] = sync_q;
        end
    endgenerate
endmodule // ddeb_sync

// ### hdl/ddeb_bank.v
// diagnostic enable and error register bank
`timescale 1ns/1ps
`include "ddeb_defines.vh"

module ddeb_bank (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // register access from the serial or parallel interface logic
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [`DDEB_ADDR_W-1:0] reg_addr_i,
    input wire [`DDEB_DATA_W-1:0] reg_wdata_i,
    input wire reg_addr_valid_i,
    output reg [`DDEB_DATA_W-1:0] reg_rdata_o,
    // fault events from the device checkers
    input wire if_crc_fail_i,
    input wire regmap_crc_fail_i,
    input wire rom_crc_fail_i,
    input wire [`DDEB_NCH-1:0] open_found_i,
    input wire [`DDEB_NCH-1:0] over_range_i,
    input wire [`DDEB_NCH-1:0] under_range_i,
    // conversion status pin and clocks to monitor
    input wire busy_pin_i,
    input wire conversion_rate_clock_i,
    input wire oversampling_clock_i,
    // open-detect mode strap
    input wire open_manual_mode_i,
    // conversion data path
    input wire [15:0] sample_i,
    output reg [15:0] sample_o,
    // controls toward analog and check logic, and clock monitor edge counts
    output wire [`DDEB_NCH-1:0] open_detect_arm_o,
    output wire [`DDEB_NCH-1:0] front_end_amplifier_cm_high_o,
    output wire [`DDEB_NCH-1:0] range_check_arm_o,
    output wire regmap_crc_check_enable_o,
    output wire rom_crc_check_enable_o,
    output wire if_crc_check_enable_o,
    output reg [`DDEB_MON_W-1:0] rate_clock_count_o,
    output reg [`DDEB_MON_W-1:0] os_clock_count_o
);
    reg [`DDEB_DATA_W-1:0] dig_en_q;
    reg [`DDEB_DATA_W-1:0] dig_err_q;
    reg [`DDEB_DATA_W-1:0] dig_err_d;
    reg [`DDEB_NCH-1:0] open_en_q;
    wire [`DDEB_NCH-1:0] open_flg;
    reg [`DDEB_NCH-1:0] rng_en_q;
    wire [`DDEB_NCH-1:0] ovr_flg;
    wire [`DDEB_NCH-1:0] und_flg;
    reg [`DDEB_CNT_W-1:0] stuck_cnt_q;
    reg stuck_hit;
    reg fs_prev_q;
    reg os_prev_q;
    reg [`DDEB_DATA_W-1:0] rdata_d;
    wire fs_rise;
    wire os_rise;
    wire [2:0] pin_s;
    wire busy_s;
    wire fs_s;
    wire os_s;
    wire wr_bad;
    wire rd_bad;
    wire [`DDEB_DATA_W-1:0] clr_dig;
    wire [`DDEB_NCH-1:0] clr_open;
    wire [`DDEB_NCH-1:0] clr_ovr;
    wire [`DDEB_NCH-1:0] clr_und;
    wire [`DDEB_NCH-1:0] open_arm;

    // busy and both monitor clocks arrive straight from pins
    ddeb_sync #(
        .W(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .async_i({busy_pin_i, conversion_rate_clock_i, oversampling_clock_i}),
        .sync_o(pin_s)
    );
    assign busy_s = pin_s[2];
    assign fs_s = pin_s[1];
    assign os_s = pin_s[0];

    // address validity is decoded by the outer register file
    assign wr_bad = reg_wr_i && !reg_addr_valid_i;
    assign rd_bad = reg_rd_i && !reg_addr_valid_i;

    // write-one masks; a zero bit leaves the flag alone
    assign clr_dig = (reg_wr_i && reg_addr_i == `DDEB_OFS_DIG_ERR) ? reg_wdata_i : `DDEB_RST_ZERO;
    assign clr_open = (reg_wr_i && reg_addr_i == `DDEB_OFS_OPEN_FLG) ? reg_wdata_i : `DDEB_RST_ZERO;
    assign clr_ovr = (reg_wr_i && reg_addr_i == `DDEB_OFS_OVR_FLG) ? reg_wdata_i : `DDEB_RST_ZERO;
    assign clr_und = (reg_wr_i && reg_addr_i == `DDEB_OFS_UND_FLG) ? reg_wdata_i : `DDEB_RST_ZERO;

    // open detection armed only in automatic mode
    assign open_arm = open_manual_mode_i ? `DDEB_RST_ZERO : open_en_q;
    assign open_detect_arm_o = open_arm;
    assign front_end_amplifier_cm_high_o = open_manual_mode_i ? open_en_q : `DDEB_RST_ZERO;
    assign range_check_arm_o = rng_en_q;
    assign regmap_crc_check_enable_o = dig_en_q[`DDEB_BIT_MMCRC];
    assign rom_crc_check_enable_o = dig_en_q[`DDEB_BIT_ROMCRC];
    assign if_crc_check_enable_o = dig_en_q[`DDEB_BIT_IFCRC];

    // control registers
    // only the rom crc check is armed out of reset
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            dig_en_q <= `DDEB_RST_DIG_EN;
            open_en_q <= `DDEB_RST_ZERO;
            rng_en_q <= `DDEB_RST_ZERO;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `DDEB_OFS_DIG_EN: begin
                    dig_en_q <= reg_wdata_i;
                end
                `DDEB_OFS_OPEN_EN: begin
                    open_en_q <= reg_wdata_i;
                end
                `DDEB_OFS_RNG_EN: begin
                    rng_en_q <= reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // busy stuck-high timer, saturating one past the limit
    // so a busy held high sets the flag once, never on a wrap
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            stuck_cnt_q <= {`DDEB_CNT_W{1'b0}};
        end else if (!busy_s || !dig_en_q[`DDEB_BIT_STUCK]) begin
            stuck_cnt_q <= {`DDEB_CNT_W{1'b0}};
        end else if (stuck_cnt_q <= `DDEB_STUCK_CYC) begin
            stuck_cnt_q <= stuck_cnt_q + 1'b1;
        end
    end

    always @* begin
        stuck_hit = (stuck_cnt_q == `DDEB_STUCK_CYC);
    end

    // sticky digital error flags; set wins over clear
    always @* begin
        dig_err_d = dig_err_q & ~clr_dig;
        if (stuck_hit) begin
            dig_err_d[`DDEB_BIT_STUCK] = 1'b1;
        end
        if (rd_bad && dig_en_q[`DDEB_BIT_RDERR]) begin
            dig_err_d[`DDEB_BIT_RDERR] = 1'b1;
        end
        if (wr_bad && dig_en_q[`DDEB_BIT_WRERR]) begin
            dig_err_d[`DDEB_BIT_WRERR] = 1'b1;
        end
        if (if_crc_fail_i && dig_en_q[`DDEB_BIT_IFCRC]) begin
            dig_err_d[`DDEB_BIT_IFCRC] = 1'b1;
        end
        if (regmap_crc_fail_i && dig_en_q[`DDEB_BIT_MMCRC]) begin
            dig_err_d[`DDEB_BIT_MMCRC] = 1'b1;
        end
        if (rom_crc_fail_i && dig_en_q[`DDEB_BIT_ROMCRC]) begin
            dig_err_d[`DDEB_BIT_ROMCRC] = 1'b1;
        end
        dig_err_d = dig_err_d & `DDEB_ERR_MASK;
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            dig_err_q <= `DDEB_RST_ZERO;
        end else begin
            dig_err_q <= dig_err_d;
        end
    end

    // per-channel sticky flags, gated by their enables
    // a set in the same cycle as a clear wins
    genvar ch;
    generate
        for (ch = 0; ch < `DDEB_NCH; ch = ch + 1) begin : g_ch
            reg open_q;
            reg ovr_q;
            reg und_q;
            always @(posedge clk_i) begin
                if (!rst_n_i) begin
                    open_q <= 1'b0;
                    ovr_q <= 1'b0;
                    und_q <= 1'b0;
                end else begin
                    open_q <= (open_found_i[ch] && open_arm[ch])
                        || (open_q && !clr_open[ch]);
                    ovr_q <= (over_range_i[ch] && rng_en_q[ch])
                        || (ovr_q && !clr_ovr[ch]);
                    und_q <= (under_range_i[ch] && rng_en_q[ch])
                        || (und_q && !clr_und[ch]);
                end
            end
            assign open_flg[ch] = open_q;
            assign ovr_flg[ch] = ovr_q;
            assign und_flg[ch] = und_q;
        end
    endgenerate

    // rising edges of the synchronised monitor clocks
    assign fs_rise = fs_s && !fs_prev_q;
    assign os_rise = os_s && !os_prev_q;

    // clock monitor edge counters; cleared while disabled so each enable starts at zero
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            fs_prev_q <= 1'b0;
            os_prev_q <= 1'b0;
            rate_clock_count_o <= {`DDEB_MON_W{1'b0}};
            os_clock_count_o <= {`DDEB_MON_W{1'b0}};
        end else begin
            fs_prev_q <= fs_s;
            os_prev_q <= os_s;
            if (!dig_en_q[`DDEB_BIT_CLKMON]) begin
                rate_clock_count_o <= {`DDEB_MON_W{1'b0}};
                os_clock_count_o <= {`DDEB_MON_W{1'b0}};
            end else begin
                if (fs_rise) begin
                    rate_clock_count_o <= rate_clock_count_o + 1'b1;
                end
                if (os_rise) begin
                    os_clock_count_o <= os_clock_count_o + 1'b1;
                end
            end
        end
    end

    // conversion data substitution
    // the fixed word stands in for every channel's result
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sample_o <= `DDEB_RST_SAMPLE;
        end else if (dig_en_q[`DDEB_BIT_IFCHK]) begin
            sample_o <= `DDEB_FIXED_WORD;
        end else begin
            sample_o <= sample_i;
        end
    end

    // read data next value; holds between reads
    // a read and a write in one cycle return the value before the write
    always @* begin
        rdata_d = reg_rdata_o;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `DDEB_OFS_DIG_EN: begin
                    rdata_d = dig_en_q;
                end
                `DDEB_OFS_DIG_ERR: begin
                    rdata_d = dig_err_q;
                end
                `DDEB_OFS_OPEN_EN: begin
                    rdata_d = open_en_q;
                end
                `DDEB_OFS_OPEN_FLG: begin
                    rdata_d = open_flg;
                end
                `DDEB_OFS_RNG_EN: begin
                    rdata_d = rng_en_q;
                end
                `DDEB_OFS_OVR_FLG: begin
                    rdata_d = ovr_flg;
                end
                `DDEB_OFS_UND_FLG: begin
                    rdata_d = und_flg;
                end
                default: begin
                    rdata_d = `DDEB_RST_ZERO;
                end
            endcase
        end
    end

    // registered read data
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= `DDEB_RST_ZERO;
        end else begin
            reg_rdata_o <= rdata_d;
        end
    end
endmodule // ddeb_bank

// ### tb/ddeb_checker.sv
// port assertions for the diagnostic bank
`timescale 1ns/1ps
module ddeb_checker (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // register access
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [5:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    // data path and controls
    input wire open_manual_mode_i,
    input wire [15:0] sample_i,
    input wire [15:0] sample_o,
    input wire [7:0] open_detect_arm_o,
    input wire [7:0] front_end_amplifier_cm_high_o,
    input wire [7:0] range_check_arm_o,
    input wire regmap_crc_check_enable_o,
    input wire rom_crc_check_enable_o,
    input wire if_crc_check_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire en_wr = reg_wr_i && reg_addr_i == 6'h21;
    wire en_rd = reg_rd_i && reg_addr_i == 6'h21;
    a_check_en_write: assert property (
        en_wr |=> {if_crc_check_enable_o, regmap_crc_check_enable_o, rom_crc_check_enable_o}
        == $past(reg_wdata_i[2:0])) else $error("check enables differ from write");
    a_range_en_write: assert property (
        reg_wr_i && reg_addr_i == 6'h25 |=> range_check_arm_o == $past(reg_wdata_i))
        else $error("range arm differs from write");
    a_open_en_write: assert property (
        reg_wr_i && reg_addr_i == 6'h23 |=>
        (open_detect_arm_o | front_end_amplifier_cm_high_o) == $past(reg_wdata_i))
        else $error("open enable differs from write");
    a_open_mode_split: assert property (
        (open_manual_mode_i ? open_detect_arm_o : front_end_amplifier_cm_high_o) == 8'h00)
        else $error("open control on wrong output");
    a_rdata_hold: assert property (
        !reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved without read");
    a_reserved_zero: assert property (
        reg_rd_i && reg_addr_i == 6'h22 |=> reg_rdata_o[7:6] == 2'b00)
        else $error("reserved error bits set");
    a_unmapped_zero: assert property (
        reg_rd_i && (reg_addr_i < 6'h21 || reg_addr_i > 6'h27) |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_enable_readback: assert property (
        en_wr ##1 !reg_wr_i ##1 en_rd |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("enable readback wrong");
    a_sample_path: assert property (
        1'b1 |=> sample_o == $past(sample_i) || sample_o == 16'hACE1)
        else $error("sample output neither data nor fixed word");
    a_fixed_word: assert property (
        en_wr && reg_wdata_i[7] |=> ##1 sample_o == 16'hACE1)
        else $error("fixed word missing with interface check on");
    a_live_sample: assert property (
        en_wr && !reg_wdata_i[7] |=> ##1 sample_o == $past(sample_i))
        else $error("sample not passed through with interface check off");
    a_reset_values: assert property (
        $rose(rst_n_i) |-> {if_crc_check_enable_o, regmap_crc_check_enable_o,
        rom_crc_check_enable_o} == 3'h1 && range_check_arm_o == 8'h00 && reg_rdata_o == 8'h00)
        else $error("outputs not at reset values after reset");
    c_err_read: cover property (reg_rd_i && reg_addr_i == 6'h22);
    c_fixed_on: cover property (en_wr && reg_wdata_i[7]);
    c_manual: cover property (open_manual_mode_i);
endmodule // ddeb_checker

bind ddeb_bank ddeb_checker u_chk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .open_manual_mode_i(open_manual_mode_i),
    .sample_i(sample_i),
    .sample_o(sample_o),
    .open_detect_arm_o(open_detect_arm_o),
    .front_end_amplifier_cm_high_o(front_end_amplifier_cm_high_o),
    .range_check_arm_o(range_check_arm_o),
    .regmap_crc_check_enable_o(regmap_crc_check_enable_o),
    .rom_crc_check_enable_o(rom_crc_check_enable_o),
    .if_crc_check_enable_o(if_crc_check_enable_o)
);

// ### tb/ddeb_host.sv
// host model issuing register accesses
`timescale 1ns/1ps
module ddeb_host (
    // clock
    input wire clk_i,
    // register access
    output reg reg_wr_o,
    output reg reg_rd_o,
    output reg [5:0] reg_addr_o,
    output reg [7:0] reg_wdata_o,
    output reg reg_addr_valid_o,
    input wire [7:0] reg_rdata_i
);
    task put(input w, input r, input v, input [5:0] a, input [7:0] d);
        reg_wr_o = w;
        reg_rd_o = r;
        reg_addr_valid_o = v;
        reg_addr_o = a;
        reg_wdata_o = d;
    endtask
    initial put(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    // strobe over one taking edge, then a free cycle
    task access(input w, input v, input [5:0] a, input [7:0] d, output [7:0] q);
        @(posedge clk_i);
        #1 put(w, !w, v, a, d);
        @(posedge clk_i);
        #1 q = reg_rdata_i;
        put(1'b0, 1'b0, 1'b1, ~a, ~d);
    endtask
endmodule // ddeb_host

// ### tb/tb.sv
// self-checking bench for the diagnostic bank
`timescale 1ns/1ps
module tb;
    reg clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    wire wr, rd, vld, mm_en, rom_en, if_en;
    wire [5:0] addr;
    wire [7:0] wd, rdat, arm, cm, rng;
    wire [15:0] smp_o, rcnt, ocnt;
    reg [2:0] crc = 3'b000;
    reg [7:0] opn = 8'h00, ovr = 8'h00, und = 8'h00, q;
    reg busy = 1'b0, fsc = 1'b0, osc = 1'b0, man = 1'b0;
    reg [15:0] smp = 16'h1234;
    integer failures = 0, comparisons = 0, i;
    // address, reset value, write data, value read back
    reg [31:0] rows [0:7] = '{32'h2101FFFF, 32'h2200FF00, 32'h2300A5A5, 32'h2400FF00,
        32'h25003C3C, 32'h2600FF00, 32'h2700FF00, 32'h30005500};
    always #12.5 clk_i = ~clk_i;
    ddeb_host u_host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wd), .reg_addr_valid_o(vld), .reg_rdata_i(rdat));
    ddeb_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_addr_valid_i(vld), .reg_rdata_o(rdat),
        .if_crc_fail_i(crc[2]), .regmap_crc_fail_i(crc[1]), .rom_crc_fail_i(crc[0]),
        .open_found_i(opn), .over_range_i(ovr), .under_range_i(und), .busy_pin_i(busy),
        .conversion_rate_clock_i(fsc), .oversampling_clock_i(osc),
        .open_manual_mode_i(man), .sample_i(smp), .sample_o(smp_o),
        .open_detect_arm_o(arm), .front_end_amplifier_cm_high_o(cm),
        .range_check_arm_o(rng), .regmap_crc_check_enable_o(mm_en),
        .rom_crc_check_enable_o(rom_en), .if_crc_check_enable_o(if_en),
        .rate_clock_count_o(rcnt), .os_clock_count_o(ocnt));
    task chk(input [15:0] got, input [15:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task wr8(input [5:0] a, input [7:0] d);
        u_host.access(1'b1, 1'b1, a, d, q);
    endtask
    task rd8(input [5:0] a, input [7:0] e);
        u_host.access(1'b0, 1'b1, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, e});
    endtask
    // one-cycle fault events, then invalid read and write
    task faults(input [26:0] v);
        {crc, opn, ovr, und} = v;
        tick(1);
        {crc, opn, ovr, und} = 27'h0;
        u_host.access(1'b0, 1'b0, 6'h3F, 8'h00, q);
        u_host.access(1'b1, 1'b0, 6'h3F, 8'h00, q);
    endtask
    task summarize;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        failures = failures + 1;
        summarize;
    end
    initial begin
        tick(5);
        rst_n_i = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            rd8(rows[i][29:24], rows[i][23:16]);
            wr8(rows[i][29:24], rows[i][15:8]);
            rd8(rows[i][29:24], rows[i][7:0]);
        end
        chk({8'h00, rng}, 16'h003C);
        tick(2);
        chk(smp_o, 16'hACE1);
        for (i = 0; i < 8; i = i + 1) begin
            fsc = ~fsc;
            osc = ~osc;
            tick(2);
        end
        tick(4);
        chk(rcnt, 16'h0004);
        chk(ocnt, 16'h0004);
        wr8(6'h21, 8'h01);
        tick(1);
        chk(rcnt, 16'h0000);
        chk(smp_o, 16'h1234);
        faults({3'b111, 24'hFFFFFF});
        rd8(6'h22, 8'h01);
        rd8(6'h24, 8'hA5);
        rd8(6'h26, 8'h3C);
        rd8(6'h27, 8'h3C);
        fork
            wr8(6'h26, 8'hFF);
            begin
                tick(1);
                ovr = 8'h3C;
                tick(1);
                ovr = 8'h00;
            end
        join
        rd8(6'h26, 8'h3C);
        wr8(6'h24, 8'h05);
        rd8(6'h24, 8'hA0);
        man = 1'b1;
        tick(1);
        chk({arm, cm}, 16'h00A5);
        opn = 8'hFF;
        tick(1);
        opn = 8'h00;
        rd8(6'h24, 8'hA0);
        man = 1'b0;
        tick(1);
        chk({arm, cm}, 16'hA500);
        wr8(6'h22, 8'h01);
        wr8(6'h21, 8'h3F);
        chk({13'h0000, if_en, mm_en, rom_en}, 16'h0007);
        busy = 1'b1;
        tick(150);
        busy = 1'b0;
        rd8(6'h22, 8'h00);
        busy = 1'b1;
        tick(170);
        busy = 1'b0;
        faults({3'b111, 24'h000000});
        rd8(6'h22, 8'h3F);
        wr8(6'h22, 8'h01);
        rd8(6'h22, 8'h3E);
        wr8(6'h22, 8'h3E);
        rd8(6'h22, 8'h00);
        rst_n_i = 1'b0;
        tick(3);
        rst_n_i = 1'b1;
        rd8(6'h21, 8'h01);
        chk({13'h0000, if_en, mm_en, rom_en}, 16'h0001);
        rd8(6'h24, 8'h00);
        busy = 1'b1;
        tick(170);
        busy = 1'b0;
        rd8(6'h22, 8'h00);
        summarize;
    end
endmodule // tb
